// ==== verilog/sktr_skip_test_reset.v ====
// Skip-on-flag, software system reset and serial start instruction logic.
`timescale 1ns/10ps
`include "sktr_regs.vh"

// What this block does
// - Timer-one test with enable 0 and flag 1 clears flag and skips next.
// - A flag test whose flag reads 0 does not skip.
// - Timer-one test with enable 1 is a no-operation, flag unchanged.
// - Timer-one enable comes from bit 2 of first interrupt control.
// - Timer-two test with enable 0 and flag 1 clears flag and skips next.
// - Timer-two test with enable 1 is a no-operation, flag unchanged.
// - Timer-two enable comes from bit 3 of first interrupt control.
// - Serial test with second-control enable bit 3 set is a no-operation.
// - The system reset instruction requests a full system reset.
// - A taken timer-one skip clears the timer-one flag to zero.
// - A taken timer-two skip clears the timer-two flag to zero.
// - Serial test with enable 0 and flag 1 clears flag and skips next.
// - Serial start clears the serial flag and starts a transfer.
module sktr_skip_test_reset #(
  parameter INSTR_W = `SKTR_INSTR_W
) (
  // Clock and reset
  input  wire               i_clk,
  input  wire               i_rstn,
  // Instruction stream, one instruction per valid cycle
  input  wire               i_instr_valid,
  input  wire [INSTR_W-1:0] i_instr,
  // Interrupt control registers
  input  wire [3:0]         i_irq_control_first,
  input  wire [3:0]         i_irq_control_second,
  // Peripheral request events
  input  wire               i_timer_one_event,
  input  wire               i_timer_two_event,
  input  wire               i_serial_event,
  // Request flags
  output wire               o_timer_one_request_flag,
  output wire               o_timer_two_request_flag,
  output wire               o_serial_request_flag,
  // Skip control
  output wire               o_instr_suppress,
  output wire               o_skip_pending,
  output wire               o_skip_taken,
  // Side effects
  output wire               o_sys_reset_req,
  output wire               o_serial_start
);

  localparam NF = `SKTR_NUM_FLAGS;

  localparam [2:0] OP_NONE         = 3'h0;
  localparam [2:0] OP_TEST_T1      = 3'h1;
  localparam [2:0] OP_TEST_T2      = 3'h2;
  localparam [2:0] OP_TEST_SERIAL  = 3'h3;
  localparam [2:0] OP_SYS_RESET    = 3'h4;
  localparam [2:0] OP_SERIAL_START = 3'h5;

  // Maps an instruction word onto the operations handled here.
  function [2:0] decode_op;
    input [INSTR_W-1:0] instr;
    begin
      case (instr)
        `SKTR_OP_TIMER_ONE: begin
          decode_op = OP_TEST_T1;
        end
        `SKTR_OP_TIMER_TWO: begin
          decode_op = OP_TEST_T2;
        end
        `SKTR_OP_SERIAL_TEST: begin
          decode_op = OP_TEST_SERIAL;
        end
        `SKTR_OP_SYS_RESET: begin
          decode_op = OP_SYS_RESET;
        end
        `SKTR_OP_SERIAL_START: begin
          decode_op = OP_SERIAL_START;
        end
        default: begin
          decode_op = OP_NONE;
        end
      endcase
    end
  endfunction

  // True when an executing instruction decodes to the wanted operation.
  function op_hit;
    input       run;
    input [2:0] code;
    input [2:0] want;
    begin
      op_hit = run & (code == want);
    end
  endfunction

  reg           skip_pending_r;
  reg           skip_pending_nxt;
  reg           skip_taken_r;
  reg           skip_taken_nxt;
  reg           sys_reset_req_r;
  reg           sys_reset_req_nxt;
  reg           serial_start_r;
  reg           serial_start_nxt;

  wire          exec;
  wire [2:0]    op;
  wire [NF-1:0] flag;
  wire [NF-1:0] irq_enable;
  wire [NF-1:0] set_evt;
  wire [NF-1:0] is_test;
  wire [NF-1:0] skip_hit;
  wire [NF-1:0] flag_clr;
  wire          any_skip;
  wire          exec_sys_reset;
  wire          exec_serial_start;

  // An instruction executes unless a prior taken skip suppresses it.
  assign o_instr_suppress = i_instr_valid & skip_pending_r;
  assign exec = i_instr_valid & ~skip_pending_r;
  assign op   = decode_op(i_instr);

  assign irq_enable[`SKTR_IDX_TIMER_ONE] = i_irq_control_first[`SKTR_TIMER_ONE_EN_BIT];
  assign irq_enable[`SKTR_IDX_TIMER_TWO] = i_irq_control_first[`SKTR_TIMER_TWO_EN_BIT];
  assign irq_enable[`SKTR_IDX_SERIAL]    = i_irq_control_second[`SKTR_SERIAL_EN_BIT];

  assign set_evt[`SKTR_IDX_TIMER_ONE] = i_timer_one_event;
  assign set_evt[`SKTR_IDX_TIMER_TWO] = i_timer_two_event;
  assign set_evt[`SKTR_IDX_SERIAL]    = i_serial_event;

  assign is_test[`SKTR_IDX_TIMER_ONE] = op_hit(exec, op, OP_TEST_T1);
  assign is_test[`SKTR_IDX_TIMER_TWO] = op_hit(exec, op, OP_TEST_T2);
  assign is_test[`SKTR_IDX_SERIAL]    = op_hit(exec, op, OP_TEST_SERIAL);
  assign exec_sys_reset               = op_hit(exec, op, OP_SYS_RESET);
  assign exec_serial_start            = op_hit(exec, op, OP_SERIAL_START);

  genvar g;
  generate
    for (g = 0; g < NF; g = g + 1) begin : g_flag
      // Enabled interrupt turns the test into a no-operation; a zero flag never skips.
      assign skip_hit[g] = is_test[g] & ~irq_enable[g] &
                           flag[g];
      sktr_flag_cell u_flag (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_set  (set_evt[g]),
        .i_clr  (flag_clr[g]),
        .o_flag (flag[g])
      );
    end
  endgenerate

  assign flag_clr[`SKTR_IDX_TIMER_ONE] = skip_hit[`SKTR_IDX_TIMER_ONE];
  assign flag_clr[`SKTR_IDX_TIMER_TWO] = skip_hit[`SKTR_IDX_TIMER_TWO];
  assign flag_clr[`SKTR_IDX_SERIAL]    = skip_hit[`SKTR_IDX_SERIAL] |
                                         exec_serial_start;

  assign any_skip = |skip_hit;

  // The pending skip lasts until exactly one further instruction is consumed.
  // A test that is itself suppressed never skips, so a run of tests skips
  // on every other one rather than chaining.
  always @* begin
    skip_pending_nxt = skip_pending_r;
    if (i_instr_valid) begin
      skip_pending_nxt = ~skip_pending_r & any_skip;
    end
  end

  // Pulses follow executed instructions only; a suppressed one has no effect.
  always @* begin
    skip_taken_nxt    = any_skip;
    sys_reset_req_nxt = exec_sys_reset;
    serial_start_nxt  = exec_serial_start;
  end

  // Skip waiting for the next instruction.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      skip_pending_r <= 1'b0;
    end else begin
      skip_pending_r <= skip_pending_nxt;
    end
  end

  // One-cycle report that a skip was taken.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      skip_taken_r <= 1'b0;
    end else begin
      skip_taken_r <= skip_taken_nxt;
    end
  end

  // Request to the reset controller; this block does not reset itself from it.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sys_reset_req_r <= 1'b0;
    end else begin
      sys_reset_req_r <= sys_reset_req_nxt;
    end
  end

  // Start strobe for the serial transfer.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      serial_start_r <= 1'b0;
    end else begin
      serial_start_r <= serial_start_nxt;
    end
  end

  // Flag levels straight from the cells.
  assign o_timer_one_request_flag = flag[`SKTR_IDX_TIMER_ONE];
  assign o_timer_two_request_flag = flag[`SKTR_IDX_TIMER_TWO];
  assign o_serial_request_flag    = flag[`SKTR_IDX_SERIAL];

  // Registered skip state and side-effect pulses.
  assign o_skip_pending           = skip_pending_r;
  assign o_skip_taken             = skip_taken_r;
  assign o_sys_reset_req          = sys_reset_req_r;
  assign o_serial_start           = serial_start_r;

endmodule

// ==== verilog/sktr_regs.vh ====
// Constants for the skip, test and reset instruction block.
`ifndef SKTR_REGS_VH
`define SKTR_REGS_VH

`define SKTR_INSTR_W          10
`define SKTR_OP_TIMER_ONE     10'h280
`define SKTR_OP_TIMER_TWO     10'h281
`define SKTR_OP_SERIAL_TEST   10'h288
`define SKTR_OP_SYS_RESET     10'h001
`define SKTR_OP_SERIAL_START  10'h29e

`define SKTR_TIMER_ONE_EN_BIT 2
`define SKTR_TIMER_TWO_EN_BIT 3
`define SKTR_SERIAL_EN_BIT    3

`define SKTR_FLAG_RST         1'b0
`define SKTR_NUM_FLAGS        3
`define SKTR_IDX_TIMER_ONE    0
`define SKTR_IDX_TIMER_TWO    1
`define SKTR_IDX_SERIAL       2

`endif

// ==== verilog/sktr_flag_cell.v ====
// One request flag: set by its peripheral event, cleared by an instruction.
`timescale 1ns/10ps
`include "sktr_regs.vh"

module sktr_flag_cell (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rstn,
  // Set and clear
  input  wire i_set,
  input  wire i_clr,
  // Flag state
  output wire o_flag
);

  reg flag_r;
  wire flag_nxt;

  // An event in the clearing cycle survives the clear.
  assign flag_nxt = i_set | (flag_r & ~i_clr);

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_r <= `SKTR_FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign o_flag = flag_r;

endmodule

// ==== tb/sktr_chk.sv ====
// Checker for the skip, test and reset instruction block.
`timescale 1ns/10ps
module sktr_chk #(
  parameter INSTR_W = 10
) (
  input wire               i_clk,
  input wire               i_rstn,
  input wire               i_instr_valid,
  input wire [INSTR_W-1:0] i_instr,
  input wire [3:0]         i_irq_control_first,
  input wire [3:0]         i_irq_control_second,
  input wire               i_timer_one_event,
  input wire               i_timer_two_event,
  input wire               i_serial_event,
  input wire               o_timer_one_request_flag,
  input wire               o_timer_two_request_flag,
  input wire               o_serial_request_flag,
  input wire               o_instr_suppress,
  input wire               o_skip_pending,
  input wire               o_skip_taken,
  input wire               o_sys_reset_req,
  input wire               o_serial_start
);
  wire ex = i_instr_valid && !o_instr_suppress;
  wire t1 = ex && i_instr == 10'h280;
  wire t2 = ex && i_instr == 10'h281;
  wire ts = ex && i_instr == 10'h288;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_skip; o_skip_pending && o_skip_taken; endsequence
  a_t1_skip: assert property (t1 && !i_irq_control_first[2] && o_timer_one_request_flag &&
    !i_timer_one_event |=> s_skip and !o_timer_one_request_flag) else $error("t1 skip");
  a_t1_nop: assert property (t1 && i_irq_control_first[2] |=> !o_skip_taken)
    else $error("t1 nop");
  a_no_flag: assert property (t1 && !o_timer_one_request_flag |=> !o_skip_pending)
    else $error("skip without flag");
  a_t2_skip: assert property (t2 && !i_irq_control_first[3] && o_timer_two_request_flag &&
    !i_timer_two_event |=> s_skip and !o_timer_two_request_flag) else $error("t2 skip");
  a_t2_nop: assert property (t2 && i_irq_control_first[3] |=> !o_skip_taken)
    else $error("t2 nop");
  a_si_skip: assert property (ts && !i_irq_control_second[3] && o_serial_request_flag &&
    !i_serial_event |=> s_skip and !o_serial_request_flag) else $error("serial skip");
  a_si_nop: assert property (ts && i_irq_control_second[3] |=> !o_skip_taken)
    else $error("serial nop");
  a_reset_req: assert property (ex && i_instr == 10'h001 |=> o_sys_reset_req)
    else $error("no reset request");
  a_start_op: assert property (ex && i_instr == 10'h29e && !i_serial_event |=>
    o_serial_start && !o_serial_request_flag) else $error("serial start");
  a_one_skip: assert property (o_skip_pending && i_instr_valid |->
    o_instr_suppress ##1 !o_skip_pending) else $error("skip not single");
  a_t1_keep: assert property (t1 && i_irq_control_first[2] && o_timer_one_request_flag |=>
    o_timer_one_request_flag) else $error("t1 flag lost");
  a_t2_keep: assert property (t2 && i_irq_control_first[3] && o_timer_two_request_flag |=>
    o_timer_two_request_flag) else $error("t2 flag lost");
  a_sup_inert: assert property (i_instr_valid && o_instr_suppress |=>
    !o_sys_reset_req && !o_serial_start && !o_skip_taken) else $error("suppressed acted");
endmodule
bind sktr_skip_test_reset sktr_chk #(.INSTR_W(INSTR_W)) chk_u (
  .i_clk                    (i_clk),
  .i_rstn                   (i_rstn),
  .i_instr_valid            (i_instr_valid),
  .i_instr                  (i_instr),
  .i_irq_control_first      (i_irq_control_first),
  .i_irq_control_second     (i_irq_control_second),
  .i_timer_one_event        (i_timer_one_event),
  .i_timer_two_event        (i_timer_two_event),
  .i_serial_event           (i_serial_event),
  .o_timer_one_request_flag (o_timer_one_request_flag),
  .o_timer_two_request_flag (o_timer_two_request_flag),
  .o_serial_request_flag    (o_serial_request_flag),
  .o_instr_suppress         (o_instr_suppress),
  .o_skip_pending           (o_skip_pending),
  .o_skip_taken             (o_skip_taken),
  .o_sys_reset_req          (o_sys_reset_req),
  .o_serial_start           (o_serial_start)
);

// ==== tb/sktr_skip_test_reset_tb.sv ====
// Self-checking bench for the skip, test and reset instruction block.
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module sktr_skip_test_reset_tb;
  reg        i_clk = 0, i_rstn = 0, i_instr_valid = 0, sup, fb;
  reg  [9:0] i_instr = 0;
  reg  [3:0] i_irq_control_first = 0, i_irq_control_second = 0;
  reg        i_timer_one_event = 0, i_timer_two_event = 0, i_serial_event = 0;
  wire       o_timer_one_request_flag, o_timer_two_request_flag, o_serial_request_flag;
  wire       o_instr_suppress, o_skip_pending, o_skip_taken, o_sys_reset_req, o_serial_start;
  wire [2:0] f = {o_serial_request_flag, o_timer_two_request_flag, o_timer_one_request_flag};
  integer    bad_count = 0, tests_run = 0, cyc = 0;
  always #4 i_clk = ~i_clk;
  sktr_skip_test_reset dut_u (
    .i_clk                    (i_clk),
    .i_rstn                   (i_rstn),
    .i_instr_valid            (i_instr_valid),
    .i_instr                  (i_instr),
    .i_irq_control_first      (i_irq_control_first),
    .i_irq_control_second     (i_irq_control_second),
    .i_timer_one_event        (i_timer_one_event),
    .i_timer_two_event        (i_timer_two_event),
    .i_serial_event           (i_serial_event),
    .o_timer_one_request_flag (o_timer_one_request_flag),
    .o_timer_two_request_flag (o_timer_two_request_flag),
    .o_serial_request_flag    (o_serial_request_flag),
    .o_instr_suppress         (o_instr_suppress),
    .o_skip_pending           (o_skip_pending),
    .o_skip_taken             (o_skip_taken),
    .o_sys_reset_req          (o_sys_reset_req),
    .o_serial_start           (o_serial_start)
  );
  task final_report;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end
  task op(input [9:0] c);
    begin
      @(posedge i_clk);
      #1 i_instr_valid = 1;
      i_instr = c;
      #2 sup = o_instr_suppress;
      @(posedge i_clk);
      #1 i_instr_valid = 0;
    end
  endtask
  task pulse(input [2:0] m);
    begin
      {i_serial_event, i_timer_two_event, i_timer_one_event} = m;
      @(posedge i_clk);
      #1 {i_serial_event, i_timer_two_event, i_timer_one_event} = 3'h0;
    end
  endtask
  task skip_case(input [9:0] c, input [2:0] m, input e, input [3:0] a, input [3:0] b, input x);
    begin
      if (e) pulse(m);
      i_irq_control_first = a;
      i_irq_control_second = b;
      fb = |(f & m);
      op(c);
      `CHK({o_skip_taken, o_skip_pending, |(f & m)}, x ? 3'h6 : {2'h0, fb})
      if (x) begin
        op(10'h001);
        `CHK({sup, o_sys_reset_req, o_skip_pending}, 3'h4)
      end
    end
  endtask
  task test_timer_one;
    begin
      skip_case(10'h280, 3'h1, 1, 4'h0, 4'h0, 1);
      skip_case(10'h280, 3'h1, 1, 4'h4, 4'h0, 0);
      skip_case(10'h280, 3'h1, 0, 4'hb, 4'hf, 1);
      skip_case(10'h280, 3'h1, 0, 4'h0, 4'h0, 0);
      $display("timer one done");
    end
  endtask
  task test_timer_two;
    begin
      skip_case(10'h281, 3'h2, 1, 4'h0, 4'h0, 1);
      skip_case(10'h281, 3'h2, 1, 4'h8, 4'h0, 0);
      skip_case(10'h281, 3'h2, 0, 4'h7, 4'hf, 1);
      $display("timer two done");
    end
  endtask
  task test_serial;
    begin
      skip_case(10'h288, 3'h4, 1, 4'h0, 4'h8, 0);
      skip_case(10'h288, 3'h4, 0, 4'hf, 4'h7, 1);
      pulse(3'h4);
      op(10'h29e);
      `CHK({o_serial_start, o_serial_request_flag}, 2'h2)
      op(10'h001);
      `CHK({o_sys_reset_req, o_serial_start}, 2'h2)
      $display("serial and reset done");
    end
  endtask
  task test_mid_reset;
    begin
      pulse(3'h7);
      i_irq_control_first = 4'h0;
      op(10'h280);
      i_rstn = 0;
      #2 `CHK({f, o_skip_pending, o_skip_taken, o_instr_suppress}, 6'h00)
      @(posedge i_clk);
      #1 i_rstn = 1;
      @(posedge i_clk);
      #1;
      `CHK({f, o_skip_pending, o_skip_taken, o_sys_reset_req, o_serial_start}, 7'h00)
      $display("mid-run reset done");
    end
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    #1 i_rstn = 1;
    test_timer_one;
    test_timer_two;
    test_serial;
    test_mid_reset;
    final_report;
  end
endmodule
